// ===== hdl/otps_regs.svh
// Register offsets, field positions, interrupt bits and reset values
// Included by the status block, its checker and its testbench
`ifndef OTPS_REGS_SVH
`define OTPS_REGS_SVH

`define OTPS_STATUS_OFFSET       32'h07f4_0008
`define OTPS_MODE_OFFSET         32'h07f4_0020
`define OTPS_IRQ_STATUS_OFFSET   32'h07f4_0024
`define OTPS_IRQ_MASK_OFFSET     32'h07f4_0028
`define OTPS_ADDR_MASK           32'hffff_fffc

`define OTPS_NWORDS_MSB          29
`define OTPS_NWORDS_LSB          16
`define OTPS_FWORDS_MSB          11
`define OTPS_FWORDS_LSB          8
`define OTPS_RERR_BIT            7
`define OTPS_ARDY_BIT            6
`define OTPS_TERR_BIT            5
`define OTPS_TRDY_BIT            4
`define OTPS_PZERO_BIT           3
`define OTPS_PCOR_BIT            2
`define OTPS_PUNC_BIT            1
`define OTPS_PRDY_BIT            0

`define OTPS_IRQ_RERR_BIT        0
`define OTPS_IRQ_ADONE_BIT       1
`define OTPS_IRQ_TDONE_BIT       2
`define OTPS_IRQ_PDONE_BIT       3
`define OTPS_IRQ_WIDTH           4

`define OTPS_READY_RESET         1'b1
`define OTPS_FLAG_RESET          1'b0
`define OTPS_MODE_RESET          3'h0

`endif

// ===== hdl/otps_pkg.sv
// Types shared by the status block: controller modes
// Standalone package, no dependencies
package otps_pkg;

    typedef enum logic [2:0] {
        OTPS_STANDBY_MODE         = 3'h0,
        OTPS_MANUAL_READ_MODE     = 3'h1,
        OTPS_MANUAL_PROGRAM_MODE  = 3'h2,
        OTPS_AUTOMATIC_READ_MODE  = 3'h3,
        OTPS_AUTOMATIC_PROGRAM_MODE = 3'h4,
        OTPS_BLANK_CHECK_TEST_MODE = 3'h5,
        OTPS_DECODER_TEST_MODE    = 3'h6,
        OTPS_WRITE_TEST_MODE      = 3'h7
    } otps_mode_t;

    typedef enum {
        OTPS_IDLE,
        OTPS_BUSY
    } otps_phase_t;

endpackage : otps_pkg

// ===== hdl/otps_sync.sv
// Three-stage synchroniser for asynchronous level inputs
// Change is accepted once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module otps_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_sync_out = sync_out;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
                next_sync_out[i] = stage3[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1   <= '0;
            stage2   <= '0;
            stage3   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            stage2   <= stage1;
            stage3   <= stage2;
            sync_out <= next_sync_out;
        end
    end
endmodule : otps_sync
`default_nettype wire

// ===== hdl/otps_flags.sv
// Sticky event flags with write-one-to-clear and a masked level interrupt
// Events come from the same clock domain
`timescale 1ns/100ps
`default_nettype none
module otps_flags #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Events and software access
    input  wire logic [WIDTH-1:0] event_set,
    input  wire logic [WIDTH-1:0] clear_ones,
    input  wire logic [WIDTH-1:0] mask,
    // State
    output var  logic [WIDTH-1:0] flags,
    output var  logic             irq
);
    logic [WIDTH-1:0] next_flags;
    logic             next_irq;

    always_comb begin
        // Set wins over a clear in the same cycle
        next_flags = (flags & ~clear_ones) | event_set;
        next_irq   = |(next_flags & mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= '0;
            irq   <= 1'b0;
        end else begin
            flags <= next_flags;
            irq   <= next_irq;
        end
    end
endmodule : otps_flags
`default_nettype wire

// ===== hdl/otps_status.sv
// Status register of the one-time-programmable memory controller, APB slave
// Assumes the controller core drives progress and result strobes on pclk;
// the double-error report arrives from another domain and is synchronised.
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "otps_regs.svh"
module otps_status #(
    parameter int NWORDS_WIDTH = 14,
    parameter int FWORDS_WIDTH = 4
) (
    // Clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic                         pready,
    output logic [31:0]                  prdata,
    output logic                         pslverr,
    // Controller core progress
    input  wire logic [NWORDS_WIDTH-1:0] words_remaining_in,
    input  wire logic [FWORDS_WIDTH-1:0] buffer_words_in,
    input  wire logic                    read_done,
    input  wire logic                    read_double_error_async,
    input  wire logic                    auto_busy,
    input  wire logic                    test_busy,
    input  wire logic                    test_done,
    input  wire logic                    test_failed,
    input  wire logic                    program_busy,
    input  wire logic                    word_done,
    input  wire logic                    word_was_zero,
    input  wire logic [1:0]              word_failed_bits,
    // Mode to the core
    output logic [2:0]                   controller_mode_select,
    // Interrupt
    output logic                         irq
);
    otps_pkg::otps_mode_t mode;
    otps_pkg::otps_mode_t next_mode;

    logic [NWORDS_WIDTH-1:0] words_remaining_count;
    logic [FWORDS_WIDTH-1:0] buffer_word_count;
    logic                    read_double_error_flag;
    logic                    auto_mode_ready;
    logic                    test_failure_flag;
    logic                    test_mode_ready;
    logic                    zero_word_skipped;
    logic                    program_correctable_error;
    logic                    program_uncorrectable_error;
    logic                    program_ready;
    logic [NWORDS_WIDTH-1:0] next_words_remaining_count;
    logic [FWORDS_WIDTH-1:0] next_buffer_word_count;
    logic                    next_read_double_error_flag;
    logic                    next_auto_mode_ready;
    logic                    next_test_failure_flag;
    logic                    next_test_mode_ready;
    logic                    next_zero_word_skipped;
    logic                    next_program_correctable_error;
    logic                    next_program_uncorrectable_error;
    logic                    next_program_ready;

    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic [2:0]  next_controller_mode_select;
    logic [`OTPS_IRQ_WIDTH-1:0] irq_mask;
    logic [`OTPS_IRQ_WIDTH-1:0] next_irq_mask;
    logic [`OTPS_IRQ_WIDTH-1:0] irq_flags;
    logic [`OTPS_IRQ_WIDTH-1:0] irq_events;
    logic [`OTPS_IRQ_WIDTH-1:0] irq_clear;
    logic        rerr_sync;
    logic        auto_active;
    logic        test_active;
    logic        auto_prog;
    logic        read_mode;
    logic        access;
    logic        wr_access;
    logic        rd_access;
    logic        stat_clear;
    logic        prev_ready_auto;
    logic        prev_ready_test;
    logic        prev_ready_prog;

    // Word-aligned register match
    function automatic logic hit(input logic [31:0] addr, input logic [31:0] offset);
        hit = (addr & `OTPS_ADDR_MASK) == offset;
    endfunction : hit

    // True for the three test modes
    function automatic logic is_test(input otps_pkg::otps_mode_t m);
        is_test = (m == otps_pkg::OTPS_BLANK_CHECK_TEST_MODE) ||
                  (m == otps_pkg::OTPS_DECODER_TEST_MODE) ||
                  (m == otps_pkg::OTPS_WRITE_TEST_MODE);
    endfunction : is_test

    // Double-error report runs on the decoder's own timing
    otps_sync #(
        .WIDTH (1)
    ) u_rerr_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (read_double_error_async),
        .sync_out (rerr_sync)
    );

    // APB decode; one wait state, high pready stops a second take
    assign access    = psel && penable && !pready;
    assign wr_access = access && pwrite;
    assign rd_access = access && !pwrite;
    assign stat_clear = wr_access && hit(paddr, `OTPS_STATUS_OFFSET) && pstrb[0]
                        && pwdata[`OTPS_RERR_BIT];

    // Automatic and test ready flags drop only while the selected mode is busy; program ready drops whenever program_busy is high
    assign auto_prog   = (mode == otps_pkg::OTPS_AUTOMATIC_PROGRAM_MODE);
    assign read_mode   = (mode == otps_pkg::OTPS_MANUAL_READ_MODE) ||
                         (mode == otps_pkg::OTPS_AUTOMATIC_READ_MODE);
    assign auto_active = ((mode == otps_pkg::OTPS_AUTOMATIC_READ_MODE) || auto_prog)
                         && auto_busy;
    assign test_active = is_test(mode) && test_busy;

    // Software control: mode and interrupt mask
    always_comb begin
        next_mode = mode;
        next_controller_mode_select = controller_mode_select;
        next_irq_mask = irq_mask;
        if (wr_access && hit(paddr, `OTPS_MODE_OFFSET) && pstrb[0]) begin
            next_mode = otps_pkg::otps_mode_t'(pwdata[2:0]);
            next_controller_mode_select = pwdata[2:0];
        end
        if (wr_access && hit(paddr, `OTPS_IRQ_MASK_OFFSET) && pstrb[0]) begin
            next_irq_mask = pwdata[`OTPS_IRQ_WIDTH-1:0];
        end
    end

    always_comb begin
        next_words_remaining_count = words_remaining_in;
        next_buffer_word_count     = buffer_words_in;
        next_auto_mode_ready       = !auto_active;
        next_test_mode_ready       = !test_active;
        next_program_ready         = !program_busy;
        next_test_failure_flag     = test_failure_flag;
        if (test_done) begin
            next_test_failure_flag = test_failed;
        end
        // Set wins over the write-one clear
        next_read_double_error_flag = read_double_error_flag;
        if (stat_clear) begin
            next_read_double_error_flag = 1'b0;
        end
        if (read_done && rerr_sync && read_mode) begin
            next_read_double_error_flag = 1'b1;
        end
        // Manual program reports each word, automatic program ORs them
        next_zero_word_skipped           = zero_word_skipped;
        next_program_correctable_error   = program_correctable_error;
        next_program_uncorrectable_error = program_uncorrectable_error;
        if (word_done) begin
            if (auto_prog) begin
                next_zero_word_skipped = zero_word_skipped | word_was_zero;
                next_program_correctable_error = program_correctable_error
                                                 | (word_failed_bits == 2'd1);
                next_program_uncorrectable_error = program_uncorrectable_error
                                                   | (word_failed_bits == 2'd2);
            end else begin
                next_zero_word_skipped = word_was_zero;
                next_program_correctable_error = (word_failed_bits == 2'd1);
                next_program_uncorrectable_error = (word_failed_bits == 2'd2);
            end
        end
        // Fresh automatic program run starts with clean results
        if (auto_prog && auto_busy && auto_mode_ready && !word_done) begin
            next_zero_word_skipped           = 1'b0;
            next_program_correctable_error   = 1'b0;
            next_program_uncorrectable_error = 1'b0;
        end
    end

    // Completion events for the interrupt status
    always_comb begin
        irq_events = '0;
        irq_events[`OTPS_IRQ_RERR_BIT]  = read_done && rerr_sync && read_mode;
        irq_events[`OTPS_IRQ_ADONE_BIT] = auto_mode_ready && !prev_ready_auto;
        irq_events[`OTPS_IRQ_TDONE_BIT] = test_mode_ready && !prev_ready_test;
        irq_events[`OTPS_IRQ_PDONE_BIT] = program_ready && !prev_ready_prog;
        irq_clear = '0;
        if (wr_access && hit(paddr, `OTPS_IRQ_STATUS_OFFSET) && pstrb[0]) begin
            irq_clear = pwdata[`OTPS_IRQ_WIDTH-1:0];
        end
    end

    otps_flags #(
        .WIDTH (`OTPS_IRQ_WIDTH)
    ) u_flags (
        .pclk       (pclk),
        .presetn    (presetn),
        .event_set  (irq_events),
        .clear_ones (irq_clear),
        .mask       (irq_mask),
        .flags      (irq_flags),
        .irq        (irq)
    );

    // Read mux; reserved and unmapped bits read zero
    always_comb begin
        next_prdata  = prdata;
        next_pready  = access;
        next_pslverr = 1'b0;
        if (access) begin
            next_prdata = 32'h0000_0000;
            if (hit(paddr, `OTPS_STATUS_OFFSET)) begin
                if (rd_access) begin
                    next_prdata[`OTPS_NWORDS_MSB:`OTPS_NWORDS_LSB] =
                        14'(words_remaining_count);
                    next_prdata[`OTPS_FWORDS_MSB:`OTPS_FWORDS_LSB] =
                        4'(buffer_word_count);
                    next_prdata[`OTPS_RERR_BIT]  = read_double_error_flag;
                    next_prdata[`OTPS_ARDY_BIT]  = auto_mode_ready;
                    next_prdata[`OTPS_TERR_BIT]  = test_failure_flag;
                    next_prdata[`OTPS_TRDY_BIT]  = test_mode_ready;
                    next_prdata[`OTPS_PZERO_BIT] = zero_word_skipped;
                    next_prdata[`OTPS_PCOR_BIT]  = program_correctable_error;
                    next_prdata[`OTPS_PUNC_BIT]  = program_uncorrectable_error;
                    next_prdata[`OTPS_PRDY_BIT]  = program_ready;
                end
            end else if (hit(paddr, `OTPS_MODE_OFFSET)) begin
                next_prdata[2:0] = controller_mode_select;
            end else if (hit(paddr, `OTPS_IRQ_STATUS_OFFSET)) begin
                next_prdata[`OTPS_IRQ_WIDTH-1:0] = irq_flags;
            end else if (hit(paddr, `OTPS_IRQ_MASK_OFFSET)) begin
                next_prdata[`OTPS_IRQ_WIDTH-1:0] = irq_mask;
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode                        <= otps_pkg::OTPS_STANDBY_MODE;
            controller_mode_select      <= `OTPS_MODE_RESET;
            irq_mask                    <= '0;
            words_remaining_count       <= '0;
            buffer_word_count           <= '0;
            read_double_error_flag      <= `OTPS_FLAG_RESET;
            auto_mode_ready             <= `OTPS_READY_RESET;
            test_failure_flag           <= `OTPS_FLAG_RESET;
            test_mode_ready             <= `OTPS_READY_RESET;
            zero_word_skipped           <= `OTPS_FLAG_RESET;
            program_correctable_error   <= `OTPS_FLAG_RESET;
            program_uncorrectable_error <= `OTPS_FLAG_RESET;
            program_ready               <= `OTPS_READY_RESET;
            prev_ready_auto             <= `OTPS_READY_RESET;
            prev_ready_test             <= `OTPS_READY_RESET;
            prev_ready_prog             <= `OTPS_READY_RESET;
            prdata                      <= 32'h0000_0000;
            pready                      <= 1'b0;
            pslverr                     <= 1'b0;
        end else begin
            mode                        <= next_mode;
            controller_mode_select      <= next_controller_mode_select;
            irq_mask                    <= next_irq_mask;
            words_remaining_count       <= next_words_remaining_count;
            buffer_word_count           <= next_buffer_word_count;
            read_double_error_flag      <= next_read_double_error_flag;
            auto_mode_ready             <= next_auto_mode_ready;
            test_failure_flag           <= next_test_failure_flag;
            test_mode_ready             <= next_test_mode_ready;
            zero_word_skipped           <= next_zero_word_skipped;
            program_correctable_error   <= next_program_correctable_error;
            program_uncorrectable_error <= next_program_uncorrectable_error;
            program_ready               <= next_program_ready;
            prev_ready_auto             <= auto_mode_ready;
            prev_ready_test             <= test_mode_ready;
            prev_ready_prog             <= program_ready;
            prdata                      <= next_prdata;
            pready                      <= next_pready;
            pslverr                     <= next_pslverr;
        end
    end
endmodule : otps_status
`default_nettype wire

// ===== test/otps_status_checker.sv
// Checker for the status block: read-back fields and mode writes
// Bound to otps_status; sees only its ports
`timescale 1ns/100ps
`default_nettype none
`include "otps_regs.svh"
module otps_status_checker #(
    parameter int NWORDS_WIDTH = 14,
    parameter int FWORDS_WIDTH = 4
) (
    // Clock and reset
    input wire logic                    pclk,
    input wire logic                    presetn,
    // APB
    input wire logic                    pwrite,
    input wire logic [31:0]             paddr,
    input wire logic [31:0]             pwdata,
    input wire logic                    pready,
    input wire logic [31:0]             prdata,
    input wire logic                    pslverr,
    // Core and mode
    input wire logic [NWORDS_WIDTH-1:0] words_remaining_in,
    input wire logic [FWORDS_WIDTH-1:0] buffer_words_in,
    input wire logic                    auto_busy,
    input wire logic                    test_busy,
    input wire logic                    program_busy,
    input wire logic [2:0]              controller_mode_select
);
    localparam int CW = NWORDS_WIDTH + FWORDS_WIDTH + 6;
    logic          st_acc;
    logic          st_rd;
    logic [CW-1:0] core;
    logic [CW-1:0] prev;
    logic [1:0]    calm;
    logic [1:0]    next_calm;
    logic          held;
    logic          next_held;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    assign st_acc = pready && !pslverr && paddr == `OTPS_STATUS_OFFSET;
    assign st_rd  = st_acc && !pwrite;
    assign core   = {words_remaining_in, buffer_words_in, auto_busy, test_busy, program_busy,
                     controller_mode_select};

    // Cycles with steady core inputs; last read-error value seen
    always_comb begin
        next_calm = (core != prev) ? 2'h0 : ((calm == 2'h3) ? 2'h3 : calm + 2'h1);
        next_held = (st_acc && pwrite && pwdata[7]) ? 1'b0 : (st_rd ? prdata[7] : held);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= '0;
            calm <= 2'h0;
            held <= 1'b0;
        end else begin
            prev <= core;
            calm <= next_calm;
            held <= next_held;
        end
    end

    reserved_zero_a:
        assert property (st_rd |-> prdata[31:30] == 2'h0 && prdata[15:12] == 4'h0)
        else $error("Reserved status bits not zero");
    words_live_a:
        assert property (st_rd && calm == 2'h3 |-> prdata[29:16] == 14'(words_remaining_in))
        else $error("Words remaining field wrong");
    buffer_count_a:
        assert property (st_rd && calm == 2'h3 |-> prdata[11:8] == 4'(buffer_words_in))
        else $error("Buffer count field wrong");
    read_error_sticky_a:
        assert property (st_rd && held |-> prdata[7])
        else $error("Read error flag cleared without write of one");
    auto_ready_a:
        assert property (st_rd && calm == 2'h3 |->
            prdata[6] == !(auto_busy && controller_mode_select inside {3'h3, 3'h4}))
        else $error("Automatic ready flag wrong");
    test_ready_a:
        assert property (st_rd && calm == 2'h3 |->
            prdata[4] == !(test_busy && controller_mode_select >= 3'h5))
        else $error("Test ready flag wrong");
    program_ready_a:
        assert property (st_rd && calm == 2'h3 |-> prdata[0] == !program_busy)
        else $error("Program ready flag wrong");
    mode_write_a:
        assert property (pready && pwrite && !pslverr && paddr == `OTPS_MODE_OFFSET |->
            controller_mode_select == pwdata[2:0])
        else $error("Mode not taken from write");
endmodule : otps_status_checker

bind otps_status otps_status_checker #(
    .NWORDS_WIDTH(NWORDS_WIDTH),
    .FWORDS_WIDTH(FWORDS_WIDTH)
) u_otps_status_checker (
    .pclk(pclk), .presetn(presetn), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .words_remaining_in(words_remaining_in), .buffer_words_in(buffer_words_in),
    .auto_busy(auto_busy), .test_busy(test_busy), .program_busy(program_busy),
    .controller_mode_select(controller_mode_select)
);
`default_nettype wire

// ===== test/otps_status_tb_top.sv
// Testbench for the status block: APB master and scenario tasks
// Drives every core input itself; the checker is bound to the design
`timescale 1ns/100ps
`default_nettype none
`include "otps_regs.svh"
module otps_status_tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [13:0] words_remaining_in;
    logic [3:0]  buffer_words_in;
    logic        read_done;
    logic        read_double_error_async;
    logic        auto_busy;
    logic        test_busy;
    logic        test_done;
    logic        test_failed;
    logic        program_busy;
    logic        word_done;
    logic        word_was_zero;
    logic [1:0]  word_failed_bits;
    logic [2:0]  controller_mode_select;
    logic        irq;
    logic [31:0] rd;
    logic        er;
    int          mismatches;
    int          total_checks;

    otps_status u_otps_status (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .words_remaining_in(words_remaining_in),
        .buffer_words_in(buffer_words_in), .read_done(read_done),
        .read_double_error_async(read_double_error_async), .auto_busy(auto_busy),
        .test_busy(test_busy), .test_done(test_done), .test_failed(test_failed),
        .program_busy(program_busy), .word_done(word_done), .word_was_zero(word_was_zero),
        .word_failed_bits(word_failed_bits), .controller_mode_select(controller_mode_select),
        .irq(irq)
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            $display("Error at %0t: no answer on the register bus", $time);
            tally_and_finish();
        end
    endtask : apb

    task automatic st_chk(input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, `OTPS_STATUS_OFFSET, 32'h0000_0000);
        check(rd & m, e);
    endtask : st_chk

    task automatic word(input logic z, input logic [1:0] f);
        @(posedge pclk);
        word_done        <= 1'b1;
        word_was_zero    <= z;
        word_failed_bits <= f;
        @(posedge pclk);
        word_done <= 1'b0;
        tick(3);
    endtask : word

    task automatic tdone();
        @(posedge pclk);
        test_busy <= 1'b1;
        tick(2);
        test_done <= 1'b1;
        @(posedge pclk);
        test_done <= 1'b0;
        test_busy <= 1'b0;
        tick(3);
    endtask : tdone

    task automatic t_counts();
        words_remaining_in <= 14'h3fff;
        buffer_words_in    <= 4'hf;
        tick(3);
        st_chk(32'h3fff_0f00, 32'h3fff_0f00);
        words_remaining_in <= 14'h0001;
        buffer_words_in    <= 4'h8;
        tick(3);
        st_chk(32'h3fff_0f00, 32'h0001_0800);
    endtask : t_counts

    task automatic t_rerr();
        apb(1'b1, `OTPS_MODE_OFFSET, 32'h0000_0001);
        read_double_error_async <= 1'b1;
        tick(6);
        read_done <= 1'b1;
        tick(1);
        read_done               <= 1'b0;
        read_double_error_async <= 1'b0;
        tick(3);
        st_chk(32'h0000_0080, 32'h0000_0080);
        check({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, `OTPS_IRQ_MASK_OFFSET, 32'h0000_0001);
        tick(2);
        check({31'h0, irq}, 32'h0000_0001);
        apb(1'b1, `OTPS_STATUS_OFFSET, 32'hffff_ff7f);
        st_chk(32'hffff_f0ff, 32'h0001_00d1);
        apb(1'b1, `OTPS_STATUS_OFFSET, 32'h0000_0080);
        st_chk(32'h0000_0080, 32'h0000_0000);
        apb(1'b1, `OTPS_IRQ_STATUS_OFFSET, 32'h0000_0001);
        tick(2);
        check({31'h0, irq}, 32'h0000_0000);
    endtask : t_rerr

    task automatic t_modes();
        int m;
        auto_busy    <= 1'b1;
        test_busy    <= 1'b1;
        program_busy <= 1'b1;
        for (m = 0; m < 8; m++) begin
            apb(1'b1, `OTPS_MODE_OFFSET, 32'(m));
            apb(1'b0, `OTPS_MODE_OFFSET, 32'h0000_0000);
            check(rd & 32'h0000_0007, 32'(m));
            tick(3);
            st_chk(32'h0000_0051, {25'h0, m != 3 && m != 4, 1'b0, m < 5, 4'h0});
        end
        auto_busy    <= 1'b0;
        test_busy    <= 1'b0;
        program_busy <= 1'b0;
    endtask : t_modes

    task automatic t_test();
        apb(1'b1, `OTPS_MODE_OFFSET, 32'h0000_0005);
        test_failed <= 1'b1;
        tdone();
        st_chk(32'h0000_0030, 32'h0000_0030);
        test_failed <= 1'b0;
        tdone();
        st_chk(32'h0000_0030, 32'h0000_0010);
    endtask : t_test

    task automatic t_prog();
        apb(1'b1, `OTPS_MODE_OFFSET, 32'h0000_0002);
        word(1'b1, 2'h0);
        st_chk(32'h0000_000e, 32'h0000_0008);
        word(1'b0, 2'h1);
        st_chk(32'h0000_000e, 32'h0000_0004);
        word(1'b0, 2'h2);
        st_chk(32'h0000_000e, 32'h0000_0002);
        apb(1'b1, `OTPS_MODE_OFFSET, 32'h0000_0004);
        auto_busy <= 1'b1;
        tick(3);
        word(1'b1, 2'h0);
        word(1'b0, 2'h1);
        word(1'b0, 2'h0);
        auto_busy <= 1'b0;
        tick(3);
        st_chk(32'h0000_004e, 32'h0000_004c);
    endtask : t_prog

    initial begin
        mismatches   = 0;
        total_checks = 0;
        presetn      = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, read_done, read_double_error_async, auto_busy,
         test_busy, test_done, test_failed, program_busy, word_done, word_was_zero,
         word_failed_bits, words_remaining_in, buffer_words_in} = '0;
        tick(10);
        presetn <= 1'b1;
        st_chk(32'hffff_ffff, 32'h0000_0051);
        apb(1'b0, `OTPS_MODE_OFFSET, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        t_counts();
        t_rerr();
        t_modes();
        t_test();
        t_prog();
        apb(1'b0, 32'h07f4_0030, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check({31'h0, er}, 32'h0000_0001);
        tally_and_finish();
    end
endmodule : otps_status_tb_top
`default_nettype wire
